// ===== rtl/byte_wide_io_port.sv
// byte-wide i/o port: data latch, three-state driver, service-request handshake
// assumes all inputs synchronous to CLK; strobe and selects are sampled, edges found by one-cycle delay
// Functional notes
// - mode low makes an input port, mode high an output port
// - input mode: while strobe high, register follows the parallel inputs
// - input mode: strobe falling edge freezes data and drives request low
// - input mode: drivers enabled with register data only while both selects high
// - input mode: either select low floats outputs; leaving the both-high select returns request high unless a strobe fall lands in the same cycle
// - output mode: drivers always enabled regardless of selects
// - output mode: load while primary low, secondary and strobe high; hold after fall
// - output mode: request goes high as soon as the port is deselected
// - output mode: after deselect, request stays high until next strobe falling edge
// - clear zeroes the register; request high in input mode, low in output mode
module byte_wide_io_port
	import io_port_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// configuration and clear
	input wire logic MODE,
	input wire logic CLEAR_N,
	// selects and strobe
	input wire logic SELECT_PRIMARY,
	input wire logic SELECT_SECONDARY,
	input wire logic STROBE,
	// data path
	input wire logic [7:0] PARALLEL_IN,
	output logic [7:0] PARALLEL_OUT,
	output logic PARALLEL_OUT_OE,
	// handshake
	output logic SERVICE_REQUEST_FLAG,
	// captured-word stream through two-entry buffer
	output logic WORD_VALID,
	output logic [7:0] WORD_DATA,
	input wire logic WORD_READY
);
	logic [7:0] data_q, data_d;
	logic srq_q, srq_d;
	logic strobe_q;
	logic [7:0] buf_q [BUF_DEPTH];
	logic [7:0] buf_d [BUF_DEPTH];
	logic [1:0] cnt_q, cnt_d;
	logic rd_q, rd_d;
	logic wr_q, wr_d;

	logic sel_in, sel_out, load, fall, push, pop;
	logic selected, desel;
	logic strobe_d, sel_q, sel_d;

	assign sel_in = SELECT_PRIMARY && SELECT_SECONDARY;
	assign sel_out = !SELECT_PRIMARY && SELECT_SECONDARY;
	// the decode that counts as selected depends on the mode
	assign selected = (MODE == MODE_INPUT) ? sel_in : sel_out;
	assign desel = sel_q && !selected;
	// mode is static so it simply steers the decode
	assign load = STROBE && ((MODE == MODE_INPUT) || sel_out);
	assign fall = strobe_q && !STROBE;
	// each input-mode frozen word is also offered downstream; a full buffer drops the new word and nothing already held
	assign push = fall && (MODE == MODE_INPUT) && (cnt_q != 2'(BUF_DEPTH));
	assign pop = WORD_VALID && WORD_READY;

	always_comb begin
		data_d = data_q;
		srq_d = srq_q;
		if (!CLEAR_N) begin
			data_d = DATA_RST;
			srq_d = (MODE == MODE_INPUT) ? SRQ_RST_IN : SRQ_RST_OUT;
		end else begin
			if (load)
				data_d = PARALLEL_IN;
			if (MODE == MODE_INPUT) begin
				// a fall beside a deselect wins, so a word strobed in during the read is still flagged
				if (fall)
					srq_d = 1'b0;
				else if (desel)
					srq_d = 1'b1;
			end else begin
				// deselect is an edge; as a level it would hold the flag high through every later strobe
				if (desel)
					srq_d = 1'b1;
				else if (fall)
					srq_d = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			data_q <= DATA_RST;
			srq_q <= SRQ_RST_IN;
		end else begin
			data_q <= data_d;
			srq_q <= srq_d;
		end
	end

	// edge tracking: strobe and selection as sampled at the previous clock
	always_comb begin
		strobe_d = STROBE;
		sel_d = selected;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			strobe_q <= 1'b0;
			sel_q <= 1'b0;
		end else begin
			strobe_q <= strobe_d;
			sel_q <= sel_d;
		end
	end

	always_comb begin
		buf_d = buf_q;
		cnt_d = cnt_q;
		rd_d = rd_q;
		wr_d = wr_q;
		if (push) begin
			buf_d[wr_q] = data_q;
			wr_d = !wr_q;
		end
		if (pop)
			rd_d = !rd_q;
		cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			buf_q[0] <= DATA_RST;
			buf_q[1] <= DATA_RST;
			cnt_q <= 2'h0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			buf_q <= buf_d;
			cnt_q <= cnt_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
		end
	end

	assign PARALLEL_OUT = data_q;
	assign PARALLEL_OUT_OE = (MODE == MODE_OUTPUT) || sel_in;
	assign SERVICE_REQUEST_FLAG = srq_q;
	assign WORD_VALID = cnt_q != 2'h0;
	assign WORD_DATA = buf_q[rd_q];

	property p_in_fall_srq;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_INPUT && CLEAR_N && strobe_q && !STROBE) |=> !SERVICE_REQUEST_FLAG;
	endproperty
	a_in_fall_srq: assert property (p_in_fall_srq) else $error("input strobe fall did not lower request");

	property p_in_desel;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_INPUT && CLEAR_N && desel && !fall)
		|=> SERVICE_REQUEST_FLAG;
	endproperty
	a_in_desel: assert property (p_in_desel) else $error("deselect did not return request high");

	property p_in_oe;
		@(posedge CLK) disable iff (!NRST)
		MODE == MODE_INPUT |-> PARALLEL_OUT_OE == (SELECT_PRIMARY && SELECT_SECONDARY);
	endproperty
	a_in_oe: assert property (p_in_oe) else $error("input mode driver enable wrong");

	property p_out_oe;
		@(posedge CLK) disable iff (!NRST)
		MODE == MODE_OUTPUT |-> PARALLEL_OUT_OE;
	endproperty
	a_out_oe: assert property (p_out_oe) else $error("output mode drivers not enabled");

	property p_in_follow;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_INPUT && CLEAR_N && STROBE) |=> PARALLEL_OUT == $past(PARALLEL_IN);
	endproperty
	a_in_follow: assert property (p_in_follow) else $error("register did not follow inputs");

	property p_out_load;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_OUTPUT && CLEAR_N && STROBE && !SELECT_PRIMARY && SELECT_SECONDARY)
		|=> PARALLEL_OUT == $past(PARALLEL_IN);
	endproperty
	a_out_load: assert property (p_out_load) else $error("output mode load failed");

	property p_hold;
		@(posedge CLK) disable iff (!NRST)
		(CLEAR_N && !STROBE) |=> $stable(PARALLEL_OUT);
	endproperty
	a_hold: assert property (p_hold) else $error("register changed while strobe low");

	property p_out_desel;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_OUTPUT && CLEAR_N && desel)
		|=> SERVICE_REQUEST_FLAG;
	endproperty
	a_out_desel: assert property (p_out_desel) else $error("deselect did not raise request");

	property p_out_fall;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_OUTPUT && CLEAR_N && fall && !desel)
		|=> !SERVICE_REQUEST_FLAG;
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("request not lowered on strobe fall");

	property p_clear;
		@(posedge CLK) disable iff (!NRST)
		!CLEAR_N |=> PARALLEL_OUT == 8'h00 && SERVICE_REQUEST_FLAG == (MODE == MODE_INPUT);
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not reset state");

	// the flag stands until its next set or clear event
	property p_in_hold_srq;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_INPUT && CLEAR_N && !fall && !desel)
		|=> $stable(SERVICE_REQUEST_FLAG);
	endproperty
	a_in_hold_srq: assert property (p_in_hold_srq) else $error("input request flag changed without cause");

	property p_out_stay_srq;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_OUTPUT && CLEAR_N && !fall && !desel)
		|=> $stable(SERVICE_REQUEST_FLAG);
	endproperty
	a_out_stay_srq: assert property (p_out_stay_srq) else $error("output request flag changed without cause");

	property p_in_float;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_INPUT && !(SELECT_PRIMARY && SELECT_SECONDARY)) |-> !PARALLEL_OUT_OE;
	endproperty
	a_in_float: assert property (p_in_float) else $error("outputs driven while deselected");

	property p_out_refuse;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_OUTPUT && CLEAR_N && !(!SELECT_PRIMARY && SELECT_SECONDARY))
		|=> $stable(PARALLEL_OUT);
	endproperty
	a_out_refuse: assert property (p_out_refuse) else $error("deselected output port loaded data");

	property p_out_load_oe;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_OUTPUT && CLEAR_N && STROBE && !SELECT_PRIMARY && SELECT_SECONDARY)
		|=> PARALLEL_OUT_OE;
	endproperty
	a_out_load_oe: assert property (p_out_load_oe) else $error("loaded output data not driven");

	// word buffer: each input-mode fall offers the frozen word, a full buffer refuses new ones
	property p_push_word;
		@(posedge CLK) disable iff (!NRST)
		(fall && MODE == MODE_INPUT && cnt_q == 2'h0)
		|=> WORD_VALID && WORD_DATA == $past(PARALLEL_OUT);
	endproperty
	a_push_word: assert property (p_push_word) else $error("frozen word not offered");

	property p_push_second;
		@(posedge CLK) disable iff (!NRST)
		(push && cnt_q == 2'h1 && !pop) |=> cnt_q == 2'h2;
	endproperty
	a_push_second: assert property (p_push_second) else $error("second word not stored");

	property p_full_hold;
		@(posedge CLK) disable iff (!NRST)
		(cnt_q == 2'h2 && !WORD_READY)
		|=> cnt_q == 2'h2 && $stable(WORD_DATA);
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full buffer changed while stalled");

	property p_head_stable;
		@(posedge CLK) disable iff (!NRST)
		(WORD_VALID && !WORD_READY) |=> WORD_VALID && $stable(WORD_DATA);
	endproperty
	a_head_stable: assert property (p_head_stable) else $error("offered word changed before taken");

	property p_pop_keeps_second;
		@(posedge CLK) disable iff (!NRST)
		(cnt_q == 2'h2 && WORD_READY) |=> WORD_VALID;
	endproperty
	a_pop_keeps_second: assert property (p_pop_keeps_second) else $error("second word lost on pop");

	property p_last_pop;
		@(posedge CLK) disable iff (!NRST)
		(cnt_q == 2'h1 && WORD_READY && !push) |=> !WORD_VALID;
	endproperty
	a_last_pop: assert property (p_last_pop) else $error("buffer not empty after last pop");

	property p_cnt_max;
		@(posedge CLK) disable iff (!NRST)
		cnt_q != 2'h3;
	endproperty
	a_cnt_max: assert property (p_cnt_max) else $error("buffer count beyond depth");

	property p_no_spurious_word;
		@(posedge CLK) disable iff (!NRST)
		(!WORD_VALID && !fall) |=> !WORD_VALID;
	endproperty
	a_no_spurious_word: assert property (p_no_spurious_word) else $error("word offered without strobe fall");

	property p_out_no_word;
		@(posedge CLK) disable iff (!NRST)
		(MODE == MODE_OUTPUT && !WORD_VALID) |=> !WORD_VALID;
	endproperty
	a_out_no_word: assert property (p_out_no_word) else $error("word offered in output mode");

	c_in_handshake: cover property (@(posedge CLK) disable iff (!NRST)
		MODE == MODE_INPUT && strobe_q && !STROBE ##[1:20] SELECT_PRIMARY && SELECT_SECONDARY);
	c_out_handshake: cover property (@(posedge CLK) disable iff (!NRST)
		MODE == MODE_OUTPUT && SERVICE_REQUEST_FLAG ##[1:20] !SERVICE_REQUEST_FLAG);
	c_buf_full: cover property (@(posedge CLK) disable iff (!NRST) cnt_q == 2'h2);
	c_out_deselect: cover property (@(posedge CLK) disable iff (!NRST)
		MODE == MODE_OUTPUT && desel ##1 SERVICE_REQUEST_FLAG);
	c_in_drop: cover property (@(posedge CLK) disable iff (!NRST)
		MODE == MODE_INPUT && fall && cnt_q == 2'h2);
endmodule

// ===== rtl/io_port_pkg.sv
// constants for the byte-wide parallel i/o port
// assumes a single 100 MHz clock domain
package io_port_pkg;
	localparam int DATA_W = 8;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic MODE_INPUT = 1'b0;
	localparam logic MODE_OUTPUT = 1'b1;
	localparam logic SRQ_RST_IN = 1'b1;
	localparam logic SRQ_RST_OUT = 1'b0;
	localparam int BUF_DEPTH = 2;
endpackage

// ===== sim/byte_wide_io_port_bench.sv
// bench for the byte-wide i/o port in input and output mode
// assumes the port, its package and the word sink model
module byte_wide_io_port_bench
	import io_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, nrst = 0, mode = 0, clr_n = 1, sp = 0, ss = 0, stb = 0, stall = 0, rdy, oe, srq, wv;
	logic [7:0] din = 8'h00, dout, wd, last;
	int cnt, error_cnt = 0, samples_checked = 0, cycles = 0;
	always #5 clk = ~clk;
	byte_wide_io_port i_byte_wide_io_port (.CLK(clk), .NRST(nrst), .MODE(mode), .CLEAR_N(clr_n),
		.SELECT_PRIMARY(sp), .SELECT_SECONDARY(ss), .STROBE(stb), .PARALLEL_IN(din), .PARALLEL_OUT(dout),
		.PARALLEL_OUT_OE(oe), .SERVICE_REQUEST_FLAG(srq), .WORD_VALID(wv), .WORD_DATA(wd), .WORD_READY(rdy));
	word_sink i_word_sink (.clk(clk), .stall(stall), .valid(wv), .data(wd), .ready(rdy), .last(last), .cnt(cnt));
	task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task rst(input logic m);
		nrst <= 0;
		mode <= m;
		repeat (10) @(posedge clk);
		nrst <= 1;
	endtask
	task clear;
		@(posedge clk) clr_n <= 0;
		@(posedge clk) clr_n <= 1;
		@(negedge clk);
	endtask
	// data changes as the strobe falls, so a late load would show
	task strobe(input logic [7:0] d);
		@(posedge clk) begin stb <= 1; din <= d; end
		@(posedge clk) begin stb <= 0; din <= ~d; end
		@(posedge clk);
		@(negedge clk);
	endtask
	task input_mode;
		rst(MODE_INPUT);
		stall <= 1;
		@(negedge clk) chk("flag", srq, SRQ_RST_IN);
		strobe(8'hA5);
		chk("out", dout, 8'hA5);
		chk("flag", srq, 1'b0);
		chk("oe", oe, 1'b0);
		@(posedge clk) begin sp <= 1; ss <= 1; end
		@(negedge clk) chk("oe", oe, 1'b1);
		chk("out", dout, 8'hA5);
		chk("flag", srq, 1'b0);
		@(posedge clk) ss <= 0;
		@(negedge clk) chk("oe", oe, 1'b0);
		@(negedge clk) chk("flag", srq, 1'b1);
		strobe(8'h3C);
		strobe(8'h5A);
		chk("valid", wv, 1'b1);
		chk("word", wd, 8'hA5);
		@(posedge clk) stall <= 0;
		repeat (4) @(negedge clk);
		chk("last", last, 8'h3C);
		chk("count", 8'(cnt), 8'h02);
		clear();
		chk("out", dout, DATA_RST);
		chk("flag", srq, SRQ_RST_IN);
	endtask
	task output_mode;
		rst(MODE_OUTPUT);
		clear();
		chk("flag", srq, SRQ_RST_OUT);
		chk("oe", oe, 1'b1);
		@(posedge clk) begin sp <= 0; ss <= 1; end
		strobe(8'hC3);
		chk("out", dout, 8'hC3);
		@(posedge clk) sp <= 1;
		// the deselect is sampled at the next edge and the flag rises at that same edge, so it is high by the second negedge
		repeat (2) @(negedge clk);
		chk("flag", srq, 1'b1);
		repeat (3) @(negedge clk);
		chk("flag", srq, 1'b1);
		strobe(8'h99);
		chk("out", dout, 8'hC3);
		chk("flag", srq, 1'b0);
		chk("oe", oe, 1'b1);
		@(posedge clk) sp <= 0;
		strobe(8'h66);
		chk("flag", srq, 1'b0);
		chk("out", dout, 8'h66);
	endtask
	task conclude;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// the scenarios need under a hundred cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			error_cnt++;
			conclude();
		end
	end
	initial begin
		input_mode();
		output_mode();
		conclude();
	end
endmodule

// ===== sim/word_sink.sv
// peripheral-side consumer of the captured-word stream
// assumes one clock; ready drops while the bench asks for a stall
module word_sink (
	// clock and control
	input wire logic clk,
	input wire logic stall,
	// stream
	input wire logic valid,
	input wire logic [7:0] data,
	output logic ready,
	// record of what was taken
	output logic [7:0] last,
	output int cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	initial cnt = 0;
	assign ready = !stall;
	// a word counts only at an edge where both sides agree
	always @(posedge clk) begin
		if (valid && ready) begin
			last <= data;
			cnt <= cnt + 1;
		end
	end
endmodule
